// file: src/gfpc_counter.sv
`timescale 1ns/100ps
module gfpc_counter #(
  parameter int CLK_HZ = gfpc_pkg::SYS_HZ_MAX,
  parameter logic [15:0] GATE_TICKS = gfpc_pkg::GATE_TICKS_DEF,
  parameter logic [31:0] PERIOD_TARGET = gfpc_pkg::PERIOD_TARGET_DEF
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic start,
  input wire logic measured_input_pin,
  output logic busy,
  output logic [31:0] freq_hz,
  output logic freq_valid,
  output logic [gfpc_pkg::MEAN_W-1:0] mean_period_q8,
  output logic [gfpc_pkg::DIV_W-1:0] freq_mhz,
  output logic fine_valid
);

  localparam int W = gfpc_pkg::DIV_W;
  localparam logic [W-1:0] FREQ_NUM = W'(64'(CLK_HZ) * 64'(gfpc_pkg::MHZ_PER_HZ)
                                        * 64'(gfpc_pkg::PRESC_DIV));
  localparam logic [5:0] DIV_LAST = 6'(W - 1);

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic lvl;
    gfpc_pkg::gfpc_state_t st;
    logic gate;
    logic [31:0] edge_cnt;
    logic [31:0] freq_hz;
    logic freq_valid;
    logic [31:0] tcnt;
    logic [31:0] changes;
    logic [W-1:0] num;
    logic [W-1:0] rem;
    logic [W-1:0] den;
    logic [5:0] dcnt;
    logic dphase;
    logic [gfpc_pkg::MEAN_W-1:0] mean_q8;
    logic [W-1:0] freq_mhz;
    logic fine_valid;
  } gfpc_top_regs_t;

  gfpc_top_regs_t r_q;
  gfpc_top_regs_t r_d;

  logic gate_open;
  logic gate_close;
  logic tmr_arm;
  logic lvl_next;
  logic fall;
  logic chg;
  logic [31:0] edge_next;
  logic [31:0] tcnt_inc;
  logic [31:0] changes_inc;
  logic [W-1:0] rsh;
  logic [W-1:0] nsh;
  logic ge;

  gfpc_gate_timer #(
    .GATE_TICKS(GATE_TICKS)
  ) u_gate_timer (
    .mclk(mclk),
    .rst(rst),
    .arm(tmr_arm),
    .gate_open(gate_open),
    .gate_close(gate_close)
  );

  // Input filter: a new level counts once the second and third stages agree
  assign lvl_next = (r_q.s2 == r_q.s3) ? r_q.s3 : r_q.lvl;
  assign fall = r_q.lvl & ~lvl_next;
  assign chg = r_q.lvl ^ lvl_next;
  assign edge_next = r_q.edge_cnt + 32'(r_q.gate & fall);
  assign tcnt_inc = r_q.tcnt + 32'h0000_0001;
  assign changes_inc = r_q.changes + 32'h0000_0001;

  // One restoring division step per cycle
  assign rsh = {r_q.rem[W-2:0], r_q.num[W-1]};
  assign ge = (rsh >= r_q.den);
  assign nsh = {r_q.num[W-2:0], ge};

  always_comb begin
    r_d = r_q;
    tmr_arm = 1'b0;
    r_d.s1 = measured_input_pin;
    r_d.s2 = r_q.s1;
    r_d.s3 = r_q.s2;
    r_d.lvl = lvl_next;
    if (start) begin
      // A new request aborts any measurement in progress
      tmr_arm = 1'b1;
      r_d.st = gfpc_pkg::GFPC_GATE;
      r_d.gate = 1'b0;
      r_d.edge_cnt = '0;
      r_d.freq_valid = 1'b0;
      r_d.fine_valid = 1'b0;
    end else begin
      case (r_q.st)
        gfpc_pkg::GFPC_IDLE: begin
        end
        gfpc_pkg::GFPC_GATE: begin
          if (gate_open) begin
            r_d.gate = 1'b1;
          end
          r_d.edge_cnt = edge_next;
          if (gate_close) begin
            r_d.gate = 1'b0;
            r_d.freq_hz = edge_next;
            r_d.freq_valid = 1'b1;
            if (edge_next != '0 && edge_next < gfpc_pkg::PERIOD_LIMIT_HZ) begin
              r_d.st = gfpc_pkg::GFPC_PER_ARM;
            end else begin
              r_d.st = gfpc_pkg::GFPC_IDLE;
            end
          end
        end
        gfpc_pkg::GFPC_PER_ARM: begin
          if (chg) begin
            r_d.tcnt = '0;
            r_d.changes = '0;
            r_d.st = gfpc_pkg::GFPC_PER_RUN;
          end
        end
        gfpc_pkg::GFPC_PER_RUN: begin
          r_d.tcnt = tcnt_inc;
          if (chg) begin
            r_d.changes = changes_inc;
            // Stop on the first whole period once the span reaches the target
            if (tcnt_inc >= PERIOD_TARGET && r_q.changes[0]) begin
              r_d.num = {8'h00, tcnt_inc, 8'h00};
              r_d.den = {16'h0000, 1'b0, changes_inc[31:1]};
              r_d.rem = '0;
              r_d.dcnt = '0;
              r_d.dphase = 1'b0;
              r_d.st = gfpc_pkg::GFPC_CALC;
            end
          end
        end
        gfpc_pkg::GFPC_CALC: begin
          r_d.num = nsh;
          r_d.rem = ge ? rsh - r_q.den : rsh;
          r_d.dcnt = r_q.dcnt + 6'h01;
          if (r_q.dcnt == DIV_LAST) begin
            r_d.rem = '0;
            r_d.dcnt = '0;
            if (!r_q.dphase) begin
              r_d.mean_q8 = nsh[gfpc_pkg::MEAN_W-1:0];
              r_d.num = FREQ_NUM;
              r_d.den = {8'h00, nsh[gfpc_pkg::MEAN_W-1:0]};
              r_d.dphase = 1'b1;
            end else begin
              r_d.freq_mhz = nsh;
              r_d.fine_valid = 1'b1;
              r_d.st = gfpc_pkg::GFPC_IDLE;
            end
          end
        end
        default: begin
          r_d.st = gfpc_pkg::GFPC_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      r_q <= '0;
    end else begin
      r_q <= r_d;
    end
  end

  assign busy = (r_q.st != gfpc_pkg::GFPC_IDLE);
  assign freq_hz = r_q.freq_hz;
  assign freq_valid = r_q.freq_valid;
  assign mean_period_q8 = r_q.mean_q8;
  assign freq_mhz = r_q.freq_mhz;
  assign fine_valid = r_q.fine_valid;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  AST_GATE_COUNT: assert property (
    !start && r_q.st == gfpc_pkg::GFPC_GATE && r_q.gate && fall
    |=> r_q.edge_cnt == $past(r_q.edge_cnt) + 32'h0000_0001)
    else $error("falling edge inside the gate was not counted");
  AST_GATE_IDLE_COUNT: assert property (
    !start && r_q.st == gfpc_pkg::GFPC_GATE && !r_q.gate |=> $stable(r_q.edge_cnt))
    else $error("edge counted while the gate was shut");
  AST_LOW_FREQ_PERIOD: assert property (
    !start && r_q.st == gfpc_pkg::GFPC_GATE && gate_close && edge_next != '0
    && edge_next < gfpc_pkg::PERIOD_LIMIT_HZ |=> r_q.st == gfpc_pkg::GFPC_PER_ARM)
    else $error("low gated result not followed by a period measurement");
  AST_PERIOD_ONLY_AFTER_GATE: assert property (
    r_q.st == gfpc_pkg::GFPC_PER_ARM |-> r_q.freq_valid
    && r_q.freq_hz < gfpc_pkg::PERIOD_LIMIT_HZ)
    else $error("period measurement without a completed low gated result");
  AST_FULL_RATE: assert property (
    !start && r_q.st == gfpc_pkg::GFPC_PER_RUN && !chg
    |=> r_q.tcnt == $past(r_q.tcnt) + 32'h0000_0001
    ##1 ($past(start) || r_q.tcnt != $past(r_q.tcnt)))
    else $error("period timer not running at full clock rate");
  AST_START_ON_EVENT: assert property (
    !start && r_q.st == gfpc_pkg::GFPC_PER_ARM && chg
    |=> r_q.st == gfpc_pkg::GFPC_PER_RUN && r_q.tcnt == '0)
    else $error("period timer did not start on the first change");
  AST_SPAN_TARGET: assert property (
    !start && r_q.st == gfpc_pkg::GFPC_PER_RUN && tcnt_inc < PERIOD_TARGET
    |=> r_q.st == gfpc_pkg::GFPC_PER_RUN)
    else $error("period measurement ended before the target span");
  AST_FINE_RESULT: assert property (
    !start && r_q.st == gfpc_pkg::GFPC_PER_RUN ##1 r_q.st == gfpc_pkg::GFPC_CALC
    |-> ##[1:100] (fine_valid || start))
    else $error("fine result not produced after a period measurement");
  AST_RESULT_HOLD: assert property (
    freq_valid && !start |=> freq_valid && $stable(freq_hz))
    else $error("gated result changed before the next start");

  COV_GATE_DONE: cover property (r_q.st == gfpc_pkg::GFPC_GATE && gate_close);
  COV_PERIOD_START: cover property (r_q.st == gfpc_pkg::GFPC_PER_ARM && chg);
  COV_FINE_DONE: cover property ($rose(fine_valid));

endmodule

// file: src/gfpc_gate_timer.sv
`timescale 1ns/100ps
module gfpc_gate_timer #(
  parameter logic [15:0] GATE_TICKS = gfpc_pkg::GATE_TICKS_DEF
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic arm,
  output logic gate_open,
  output logic gate_close
);

  localparam logic [15:0] CLOSE_CMP = 16'(gfpc_pkg::GATE_OPEN_CMP + GATE_TICKS);

  typedef struct packed {
    logic en;
    logic [gfpc_pkg::PRESC_W-1:0] presc;
    logic [gfpc_pkg::GATE_TMR_W-1:0] cnt;
    logic open_p;
    logic close_p;
  } gfpc_tmr_regs_t;

  gfpc_tmr_regs_t r_q;
  gfpc_tmr_regs_t r_d;
  logic tick;

  assign tick = (r_q.presc == {gfpc_pkg::PRESC_W{1'b1}});

  always_comb begin
    r_d = r_q;
    r_d.open_p = 1'b0;
    r_d.close_p = 1'b0;
    if (arm) begin
      r_d.en = 1'b1;
      r_d.presc = '0;
      r_d.cnt = '0;
    end else if (r_q.en) begin
      r_d.presc = r_q.presc + 8'h01;
      if (tick) begin
        r_d.cnt = r_q.cnt + 16'h0001;
        // Both compares use the same registered path, so their latency is equal
        if (r_q.cnt == gfpc_pkg::GATE_OPEN_CMP) begin
          r_d.open_p = 1'b1;
        end
        if (r_q.cnt == CLOSE_CMP) begin
          r_d.close_p = 1'b1;
          r_d.en = 1'b0;
        end
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      r_q <= '0;
    end else begin
      r_q <= r_d;
    end
  end

  assign gate_open = r_q.open_p;
  assign gate_close = r_q.close_p;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  AST_PRESCALE_HOLD: assert property (r_q.en && !arm && !tick |=> $stable(r_q.cnt))
    else $error("gate counter moved without a prescaler tick");
  AST_SINGLE_PASS: assert property (r_q.en |-> r_q.cnt <= CLOSE_CMP)
    else $error("gate counter passed the close compare");
  AST_EQUAL_LATENCY: assert property (
    r_q.en && !arm && tick && r_q.cnt == CLOSE_CMP |=> gate_close && !r_q.en)
    else $error("close compare did not fire one cycle after match");
  AST_OPEN_LATENCY: assert property (
    r_q.en && !arm && tick && r_q.cnt == gfpc_pkg::GATE_OPEN_CMP |=> gate_open)
    else $error("open compare did not fire one cycle after match");

endmodule

// file: src/gfpc_pkg.sv
package gfpc_pkg;

  // Gate timer: 256:1 prescaler in front of a 16-bit counter
  localparam int PRESC_DIV = 256;
  localparam int PRESC_W = 8;
  localparam int GATE_TMR_W = 16;
  // Highest system clock for which the gate fits in one pass (16 MHz)
  localparam int SYS_HZ_MAX = 32'h00F4_2400;
  // Gate ticks for one second at the highest system clock
  localparam logic [GATE_TMR_W-1:0] GATE_TICKS_DEF = GATE_TMR_W'(SYS_HZ_MAX / PRESC_DIV);
  // Timer value at which the gate opens
  localparam logic [GATE_TMR_W-1:0] GATE_OPEN_CMP = 16'h0001;

  // Below this gated result, if nonzero, a period measurement follows (25 kHz)
  localparam logic [31:0] PERIOD_LIMIT_HZ = 32'h0000_61A8;
  // Period measurement span in system clock cycles (10 million)
  localparam logic [31:0] PERIOD_TARGET_DEF = 32'h0098_9680;
  // Least high or low phase of the source during a period measurement
  localparam int MIN_PHASE_NS = 10000;

  // Fine result formats: mean period in cycles with fraction, frequency in mHz
  localparam int FRAC_BITS = 8;
  localparam int MHZ_PER_HZ = 32'h0000_03E8;
  localparam int DIV_W = 48;
  localparam int MEAN_W = 40;

  typedef enum logic [2:0] {
    GFPC_IDLE,
    GFPC_GATE,
    GFPC_PER_ARM,
    GFPC_PER_RUN,
    GFPC_CALC
  } gfpc_state_t;

endpackage

// file: tb/gfpc_src_model.sv
`timescale 1ns/100ps
module gfpc_src_model #(
  parameter int HALF_CYC = 256
) (
  input wire logic mclk,
  input wire logic run,
  output logic pin
);
  int cnt;
  initial begin
    pin = 1'b1;
    cnt = 0;
  end
  // Square wave, each phase held HALF_CYC clocks, at least 10 us at 20 MHz
  always @(posedge mclk) begin
    if (!run) begin
      pin <= 1'b1;
      cnt <= 0;
    end else if (cnt == HALF_CYC - 1) begin
      pin <= ~pin;
      cnt <= 0;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule

// file: tb/tb.sv
`timescale 1ns/100ps
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin fails++; \
  $display("FAIL %s expected %0h seen %0h", nm, e, g); end end
module tb;
  localparam logic [15:0] TICKS = 16'h0010;
  // Start edge to result: (1 + ticks) * 256 + 256 + about 2
  localparam int LAT = 4610;
  logic mclk, rst, start, src_run, pin, busy, freq_valid, fine_valid;
  logic [31:0] freq_hz;
  logic [gfpc_pkg::MEAN_W-1:0] mean_q8;
  logic [gfpc_pkg::DIV_W-1:0] fmhz;
  int fails, compares, n;
  gfpc_counter #(.CLK_HZ(20000000), .GATE_TICKS(TICKS),
    .PERIOD_TARGET(32'h0000_0040)) u_dut (.mclk(mclk), .rst(rst), .start(start),
    .measured_input_pin(pin), .busy(busy), .freq_hz(freq_hz), .freq_valid(freq_valid),
    .mean_period_q8(mean_q8), .freq_mhz(fmhz), .fine_valid(fine_valid));
  gfpc_src_model #(.HALF_CYC(256)) u_src (.mclk(mclk), .run(src_run), .pin(pin));
  always #25 mclk = ~mclk;

  task automatic end_of_test();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic pulse_start();
    @(posedge mclk);
    #5 start = 1'b1;
    @(posedge mclk);
    #5 start = 1'b0;
  endtask

  // Counts edges after the start edge until the chosen valid is high
  task automatic wait_valid(input bit fine, input int lim, output int cyc);
    cyc = 1;
    while (((fine ? fine_valid : freq_valid) !== 1'b1) && cyc < lim) begin
      @(posedge mclk);
      #1 cyc++;
    end
    if ((fine ? fine_valid : freq_valid) !== 1'b1) begin
      fails++;
      $display("FAIL wait valid expected 1 seen 0");
      end_of_test();
    end
  endtask

  task automatic t_no_input();
    src_run = 1'b0;
    pulse_start();
    `CHK("busy", 1'b1, busy)
    wait_valid(1'b0, 6000, n);
    `CHK("gate latency", 1'b1, n >= LAT - 5 && n <= LAT + 5)
    `CHK("zero count", 32'h0000_0000, freq_hz)
    repeat (200) @(posedge mclk);
    #5;
    `CHK("no period phase", 1'b0, fine_valid)
    `CHK("idle", 1'b0, busy)
    `CHK("held valid", 1'b1, freq_valid)
    $display("test no_input done");
  endtask

  task automatic t_slow_source();
    src_run = 1'b1;
    repeat (300) @(posedge mclk);
    pulse_start();
    wait_valid(1'b0, 6000, n);
    // 4096 gate cycles over a 512-cycle period give eight falling edges
    `CHK("gated count", 32'h0000_0008, freq_hz)
    `CHK("busy on", 1'b1, busy)
    `CHK("fine pending", 1'b0, fine_valid)
    wait_valid(1'b1, 4000, n);
    `CHK("mean period", 40'h00_0002_0000, mean_q8)
    `CHK("fine freq", 48'h0000_0254_0BE4, fmhz)
    `CHK("count kept", 32'h0000_0008, freq_hz)
    `CHK("valid kept", 1'b1, freq_valid)
    #1;
    `CHK("done", 1'b0, busy)
    $display("test slow_source done");
  endtask

  task automatic t_abort();
    pulse_start();
    #1;
    `CHK("valid cleared", 1'b0, freq_valid)
    `CHK("fine cleared", 1'b0, fine_valid)
    repeat (600) @(posedge mclk);
    pulse_start();
    `CHK("busy restart", 1'b1, busy)
    wait_valid(1'b0, 6000, n);
    `CHK("restart latency", 1'b1, n >= LAT - 5 && n <= LAT + 5)
    `CHK("restart count", 32'h0000_0008, freq_hz)
    wait_valid(1'b1, 4000, n);
    `CHK("restart fine", 48'h0000_0254_0BE4, fmhz)
    $display("test abort done");
  endtask

  initial begin
    mclk = 1'b0;
    rst = 1'b1;
    start = 1'b0;
    src_run = 1'b0;
    fails = 0;
    compares = 0;
    repeat (12) @(posedge mclk);
    `CHK("reset valid", 1'b0, freq_valid)
    `CHK("reset count", 32'h0000_0000, freq_hz)
    #5 rst = 1'b0;
    t_no_input();
    t_slow_source();
    t_abort();
    end_of_test();
  end
endmodule
